// ===== verilog/video_dac_pkg.sv
// Shared constants and types for the video converter input latch
package video_dac_pkg;
  localparam int          CODE_W      = 10;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          LEVELS      = 1024;
  localparam logic [9:0]  CODE_WHITE  = 10'h3FF;
  localparam logic [9:0]  CODE_BLACK  = 10'h000;
  localparam logic [9:0]  CODE_RST    = 10'h000;
  localparam logic [2:0]  CLK_SYNC_RST = 3'h0;
  localparam logic [2:0]  PIN_N_SYNC_RST = 3'h7;
  localparam logic        CLK_LVL_RST = 1'h0;
  localparam logic        PIN_N_LVL_RST = 1'h1;
  localparam logic        READY_RST   = 1'h0;

  typedef enum logic [2:0] {
    MODE_ACTIVE    = 3'h1,
    MODE_STANDBY   = 3'h2,
    MODE_POWER_OFF = 3'h4
  } power_mode_t;
endpackage

// ===== verilog/video_dac_input_latch.sv
// Pixel code capture, buffering and current steering control for one converter channel
//
// Summary of operation
// [R1] Capture all ten code bits each pixel-clock rise; a rise that finds the 16-entry buffer full loses its code
// [R2] One channel, one 10-bit code register
// [R3] 0x3FF white on true, 0x000 black
// [R4] Each set bit steers its weighted current out
// [R5] 1024 output levels, one per code
// [R6] Source supplies one code per pixel clock
// [R7] Lowest-numbered input is the code LSB
// [R8] Power-off input low shuts everything down
// [R9] Standby input low keeps reference alive
// [R10] Code held steady between pixel-clock rises
`timescale 1ns/100ps

module code_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;

  // Full refuses a push even when a pop frees a slot that cycle; keeps the flag a plain compare
  assign o_in_ready  = (st.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st.count != '0);
  assign o_out_data  = st.mem[st.rd];

  always_comb begin
    next_st = st;
    push    = i_in_valid && o_in_ready;
    pop     = i_out_ready && o_out_valid;
    if (push) begin
      next_st.mem[st.wr] = i_in_data;
      next_st.wr         = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_st.count = st.count + 1'b1;
      2'b01:   next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module video_dac_input_latch (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_pixel_clock,
  input  wire logic [9:0] i_pixel_code_in,
  input  wire logic       i_power_off_n,
  input  wire logic       i_standby_n,
  output logic [9:0]      o_true_current_out,
  output logic [9:0]      o_comp_current_out,
  output logic            o_reference_on,
  output logic            o_converter_on,
  output logic            o_in_ready,
  output logic            o_code_dropped
);
  typedef struct packed {
    logic [2:0]                 clk_sync;
    logic                       clk_lvl;
    logic [2:0]                 off_sync;
    logic                       off_lvl;
    logic [2:0]                 sby_sync;
    logic                       sby_lvl;
    logic [2:0][9:0]            code_sync;
    video_dac_pkg::power_mode_t mode;
    logic [9:0]                 true_bits;
    logic [9:0]                 comp_bits;
    logic                       ref_on;
    logic                       conv_on;
    logic                       in_ready;
    logic                       dropped;
  } latch_state_t;

  latch_state_t st;
  latch_state_t next_st;
  logic         pix_edge;
  logic         push;
  logic         pop;
  logic         fifo_ready;
  logic         fifo_valid;
  logic [9:0]   fifo_code;

  // Rising pixel clock counts only once stages two and three agree
  assign pix_edge = (st.clk_sync[1] == st.clk_sync[2]) && st.clk_sync[2] && !st.clk_lvl;
  // A powered-off device latches nothing
  assign push = pix_edge && (st.mode != video_dac_pkg::MODE_POWER_OFF);
  // Drain one code per pixel clock; standby stalls the drain so the buffer fills
  assign pop  = pix_edge && (st.mode == video_dac_pkg::MODE_ACTIVE);

  code_fifo #(
    .WIDTH (video_dac_pkg::CODE_W),
    .DEPTH (video_dac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (st.code_sync[2]),  // see [R1] see [R7]
    .o_out_valid (fifo_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_code)
  );

  always_comb begin
    next_st = st;
    next_st.clk_sync  = {st.clk_sync[1:0], i_pixel_clock};
    next_st.off_sync  = {st.off_sync[1:0], i_power_off_n};
    next_st.sby_sync  = {st.sby_sync[1:0], i_standby_n};
    // All ten bits sampled together, bit 0 kept as the LSB
    next_st.code_sync = {st.code_sync[1:0], i_pixel_code_in};  // see [R1] see [R7]
    if (st.clk_sync[1] == st.clk_sync[2]) begin
      next_st.clk_lvl = st.clk_sync[2];
    end
    if (st.off_sync[1] == st.off_sync[2]) begin
      next_st.off_lvl = st.off_sync[2];
    end
    if (st.sby_sync[1] == st.sby_sync[2]) begin
      next_st.sby_lvl = st.sby_sync[2];
    end

    // Power-off outranks standby
    if (!st.off_lvl) begin
      next_st.mode = video_dac_pkg::MODE_POWER_OFF;  // see [R8]
    end else if (!st.sby_lvl) begin
      next_st.mode = video_dac_pkg::MODE_STANDBY;  // see [R9]
    end else begin
      next_st.mode = video_dac_pkg::MODE_ACTIVE;
    end
    next_st.ref_on  = (st.mode != video_dac_pkg::MODE_POWER_OFF);  // see [R8] see [R9]
    next_st.conv_on = (st.mode == video_dac_pkg::MODE_ACTIVE);

    case (st.mode)
      video_dac_pkg::MODE_ACTIVE: begin
        // Single code register changes only on a pixel edge, so it holds a full period
        if (pop && fifo_valid) begin
          next_st.true_bits = fifo_code;  // see [R2] see [R4] see [R10]
          // Complement carries the rest of full scale: white 3FF/0, black 0/3FF
          next_st.comp_bits = video_dac_pkg::CODE_WHITE ^ fifo_code;  // see [R3] see [R5]
        end else begin
          // On wake-up the held code gets its complement back on the same edge the converter turns on
          next_st.comp_bits = video_dac_pkg::CODE_WHITE ^ st.true_bits;  // see [R3]
        end
      end
      video_dac_pkg::MODE_STANDBY,
      video_dac_pkg::MODE_POWER_OFF: begin
        // Both outputs source no current while the converter is off
        next_st.true_bits = video_dac_pkg::CODE_BLACK;
        next_st.comp_bits = video_dac_pkg::CODE_BLACK;
      end
      default: begin
        // An illegal mode falls back to the safe, quiet state
        next_st.mode      = video_dac_pkg::MODE_POWER_OFF;
        next_st.true_bits = video_dac_pkg::CODE_BLACK;
        next_st.comp_bits = video_dac_pkg::CODE_BLACK;
      end
    endcase

    next_st.in_ready = fifo_ready;
    // Source that overruns the buffer loses the code; flagged for one cycle
    next_st.dropped  = push && !fifo_ready;  // see [R6]
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st.clk_sync  <= video_dac_pkg::CLK_SYNC_RST;
      st.clk_lvl   <= video_dac_pkg::CLK_LVL_RST;
      st.off_sync  <= video_dac_pkg::PIN_N_SYNC_RST;
      st.off_lvl   <= video_dac_pkg::PIN_N_LVL_RST;
      st.sby_sync  <= video_dac_pkg::PIN_N_SYNC_RST;
      st.sby_lvl   <= video_dac_pkg::PIN_N_LVL_RST;
      st.code_sync <= '0;
      st.mode      <= video_dac_pkg::MODE_POWER_OFF;
      st.true_bits <= video_dac_pkg::CODE_RST;
      st.comp_bits <= video_dac_pkg::CODE_RST;
      st.ref_on    <= 1'b0;
      st.conv_on   <= 1'b0;
      st.in_ready  <= video_dac_pkg::READY_RST;
      st.dropped   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_true_current_out = st.true_bits;
  assign o_comp_current_out = st.comp_bits;
  assign o_reference_on     = st.ref_on;
  assign o_converter_on     = st.conv_on;
  assign o_in_ready         = st.in_ready;
  assign o_code_dropped     = st.dropped;
endmodule

// ===== verif/pixel_source.sv
// Pixel source model: pixel clock and codes
`timescale 1ns/100ps
module pixel_source (
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic [9:0] i_code,
  output logic            o_pixel_clock = 1'b0,
  output logic [9:0]      o_pixel_code = 10'h000
);
  int phase = 4;
  // Idles low only after a full high half, so no runt pulse reaches the latch
  always @(negedge i_clk) begin
    if (phase == 4 && !i_run) begin
      // Idle bus flips the code to its inverse every cycle, so a stale value never passes for a fresh one
      o_pixel_clock <= 1'b0;
      o_pixel_code  <= ~o_pixel_code;
    end else begin
      o_pixel_clock <= (phase < 4);
      if (phase == 4) o_pixel_code <= i_code;
      phase <= (phase + 1) % 8;
    end
  end
endmodule

// ===== verif/video_dac_input_latch_assertions.sv
// Port checker for the converter input latch
`timescale 1ns/100ps
module video_dac_input_latch_assertions (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_pixel_clock,
  input wire logic       i_power_off_n,
  input wire logic       i_standby_n,
  input wire logic [9:0] i_pixel_code_in,
  input wire logic [9:0] o_true_current_out,
  input wire logic [9:0] o_comp_current_out,
  input wire logic       o_reference_on,
  input wire logic       o_converter_on,
  input wire logic       o_in_ready,
  input wire logic       o_code_dropped
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_comp_mirror: assert property (o_converter_on |->
    o_comp_current_out == (10'h3FF ^ o_true_current_out)) else $error("comp mismatch");
  a_conv_needs_ref: assert property (o_converter_on |-> o_reference_on)
    else $error("conv without ref");
  a_idle_quiet: assert property (!o_converter_on && !$past(o_converter_on) |->
    o_true_current_out == 10'h000 && o_comp_current_out == 10'h000) else $error("idle current");
  a_code_hold: assert property ($changed(o_true_current_out) && o_converter_on |=>
    $stable(o_true_current_out)[*4]) else $error("code not held");
  a_off_ref: assert property ($fell(i_power_off_n) |-> ##[1:12]
    (!o_reference_on && !o_converter_on)) else $error("no power off");
  a_standby_ref: assert property ($fell(i_standby_n) && i_power_off_n |-> ##[1:12]
    (o_reference_on && !o_converter_on)) else $error("no standby");
  a_drop_full: assert property (o_code_dropped |-> !o_in_ready)
    else $error("drop while ready");
  a_drop_pulse: assert property (o_code_dropped |=> !o_code_dropped)
    else $error("drop too long");
  a_no_drop_off: assert property (!o_reference_on |-> !o_code_dropped)
    else $error("capture while powered off");
endmodule
bind video_dac_input_latch video_dac_input_latch_assertions video_dac_input_latch_assertions_i (.*);

// ===== verif/tb.sv
// Self-checking bench for the converter input latch
`timescale 1ns/100ps
module tb;
  logic       i_clk = 1'b0, i_rstn = 1'b0, run = 1'b0, off_n = 1'b1, stby_n = 1'b1;
  logic [9:0] src = 10'h000, code, o_true, o_comp, exp_code = 10'h000, q[$];
  logic       pix, ref_on, conv_on, rdy, drop;
  logic [9:0] fixed[4] = '{10'h3FF, 10'h000, 10'h001, 10'h200};
  int         err_total = 0, checks = 0, cyc = 0, mode = 0, drops = 0, seen = 0, vld = 0;
  always #5 i_clk = ~i_clk;
  pixel_source pixel_source_i (.i_clk(i_clk), .i_run(run), .i_code(src),
    .o_pixel_clock(pix), .o_pixel_code(code));
  video_dac_input_latch video_dac_input_latch_i (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_pixel_clock(pix), .i_pixel_code_in(code), .i_power_off_n(off_n),
    .i_standby_n(stby_n), .o_true_current_out(o_true), .o_comp_current_out(o_comp),
    .o_reference_on(ref_on), .o_converter_on(conv_on), .o_in_ready(rdy),
    .o_code_dropped(drop));
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Full check comes before the pop, as the buffer refuses a push while full
  task automatic send(input logic [9:0] c);
    logic full;
    // Non-blocking, so the source model never races the bench on its sampling edge
    src <= c;
    run <= 1'b1;
    @(posedge pix);
    if (mode != 0 || vld) begin
      chk("true", mode == 0 ? exp_code : 10'h000, o_true);
      chk("comp", mode == 0 ? 10'h3FF ^ exp_code : 10'h000, o_comp);
    end
    if (mode < 2) begin
      full = (q.size() == 16);
      if (mode == 0 && q.size() > 0) begin
        exp_code = q.pop_front();
        vld = 1;
      end
      if (full) drops++;
      else q.push_back(code);
    end
  endtask
  task automatic set_mode(input int m);
    run <= 1'b0;
    repeat (12) @(negedge i_clk);
    mode = m;
    vld = 0;
    // Mode 3 pulls both pins low: power-off must outrank standby
    off_n = (m < 2);
    stby_n = (m % 2 == 0);
    repeat (20) @(negedge i_clk);
    chk("ref_on", {9'h000, m < 2}, {9'h000, ref_on});
    chk("conv_on", {9'h000, m == 0}, {9'h000, conv_on});
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (drop === 1'b1) seen++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'hFB40B6C8));
    repeat (8) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk);
    foreach (fixed[k]) send(fixed[k]);
    repeat (20) send(10'($urandom));
    set_mode(1);
    repeat (18) send(10'($urandom));
    chk("in_ready", 10'h000, {9'h000, rdy});
    set_mode(3);
    repeat (2) send(10'($urandom));
    set_mode(2);
    repeat (3) send(10'($urandom));
    set_mode(0);
    repeat (20) send(10'($urandom));
    chk("dropped", 10'(drops), 10'(seen));
    chk("in_ready", {9'h000, q.size() != 16}, {9'h000, rdy});
    finish_test();
  end
endmodule
